//--- hw/asc_ctrl.sv
/*
 * serial host interface and conversion sequencer of a 16-bit
 * successive-approximation converter.
 * assumes: serial pins arrive asynchronously and are sampled by mclk
 * (much faster than the serial clock); the converter core is logic on
 * mclk that answers conv_start with one result word on result_valid.
 */
`timescale 1ns/1ps
//
// Contract
// - frame-sync pulse starts a new conversion
// - width select low 8-bit, high 16-bit
// - dsp mode: frame-sync out marks msb
// - external reference: chip select sets shutdown
// - chip select fall wakes, enables command shifting
// - serial clock edges sequence acquisition and conversion
// - output low until data at edge 8/16
// - result is unsigned binary, msb first
// - dsp conversions use external serial clock only
// - chip select high-low returns track/hold to track
// - 16-bit mode acquires for 11.5 clock cycles
// - internal reference power-down set by command bits
// - output changes falling edge, rising in dsp
// - input sampled rising edge, falling in dsp
// - end-of-conversion low when ready, internal clock
// - serial output released while chip select high
module asc_ctrl
    import asc_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire logic                cs_n,
    input  wire logic                sclk,
    input  wire logic                din,
    input  wire logic                frame_sync_in,
    input  wire logic                transfer_width_select,
    input  wire logic [RES_BITS-1:0] result_data,
    input  wire logic                result_valid,
    output logic                     result_ready,
    output logic                     dout,
    output logic                     dout_oe,
    output logic                     frame_sync_out,
    output logic                     eoc_n,
    output logic                     track_hold,
    output logic                     conv_start,
    output logic                     conv_step,
    output logic                     analog_awake,
    output logic                     ref_on,
    output logic                     buf_on,
    output logic [2:0]               analog_input_channel,
    output logic [1:0]               scan_mode
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] pin_meta;   // first stage, read only by pin_sync
    logic [4:0] pin_sync;   // second stage
    logic [4:0] pin_prev;   // previous synced value for edge finding

    // order: cs_n, sclk, din, frame_sync_in, width select
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            // start at the pins' idle levels so no false edge follows reset
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
            pin_prev <= PIN_IDLE;
        end
        else
        begin
            pin_meta <= {cs_n, sclk, din, frame_sync_in, transfer_width_select};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    wire cs_s    = pin_sync[4];
    wire din_s   = pin_sync[2];
    wire fs_s    = pin_sync[1];
    wire wide_s  = pin_sync[0];
    wire cs_fall = pin_prev[4] && !cs_s;
    wire cs_rise = !pin_prev[4] && cs_s;
    wire sc_rise = !pin_prev[3] && pin_sync[3];
    wire sc_fall = pin_prev[3] && !pin_sync[3];
    wire fs_fall = pin_prev[1] && !fs_s;
    wire fs_rise = !pin_prev[1] && fs_s;

    // ------------------------------------------------------------------
    // state and working registers
    // ------------------------------------------------------------------
    asc_state_type   state;          // sequencer state
    asc_state_type   next_state;     // state for next cycle
    logic            dsp_mode;       // frame-sync seen while selected
    logic [7:0]      cmd_reg;        // applied command word
    logic [7:0]      cmd_sh;         // command being shifted in
    logic [3:0]      cmd_cnt;        // command bits taken this frame
    logic [5:0]      half_cnt;       // serial clock edges since start
    logic [4:0]      launch_cnt;     // launch edges since start
    logic [3:0]      bit_cnt;        // result bit on the line
    logic [RES_BITS-1:0] shifter;    // result being sent

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    // edge roles swap in dsp mode
    wire launch_edge = dsp_mode ? sc_rise : sc_fall;
    wire sample_edge = dsp_mode ? sc_fall : sc_rise;
    wire any_edge    = sc_rise || sc_fall;
    wire int_clk     = cmd_reg[CMD_CLK_BIT] && !dsp_mode;
    wire [1:0] pd_sel = cmd_reg[CMD_PD_LSB +: 2];

    // a three-wire frame needs frame sync parked high at chip select fall
    wire start_3w  = cs_fall && fs_s;
    // in dsp mode the end of the host's sync pulse starts a conversion
    wire start_dsp = dsp_mode && fs_rise && !cs_s;
    wire start     = start_3w || start_dsp;

    wire [4:0] data_edge = wide_s ? DATA_EDGE_16 : DATA_EDGE_8;
    wire [5:0] acq_half  = wide_s ? ACQ_HALF_16 : ACQ_HALF_8;
    wire hold_now  = (state == ST_ACQ) && any_edge
                     && (half_cnt + 6'h01 == acq_half);
    wire at_data   = launch_edge && (launch_cnt + 5'h01 >= data_edge);
    wire fifo_vld;
    wire [RES_BITS-1:0] fifo_word;
    wire load_msb  = (state == ST_CONV) && at_data && fifo_vld;
    wire last_bit  = (state == ST_OUT) && launch_edge && (bit_cnt == LAST_BIT);
    wire cmd_take  = (state != ST_OFF) && sample_edge
                     && (cmd_cnt < 4'(CMD_BITS));
    wire cmd_done  = cmd_take && (cmd_cnt == 4'(CMD_BITS - 1));

    // ------------------------------------------------------------------
    // result buffer between converter core and shifter
    // ------------------------------------------------------------------
    asc_fifo #(
        .WIDTH (RES_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_data   (result_data),
        .in_valid  (result_valid),
        .in_ready  (result_ready),
        .out_data  (fifo_word),
        .out_valid (fifo_vld),
        .out_ready (load_msb)
    );

    // ------------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_OFF:
                if (start)
                    next_state = ST_ACQ;
            ST_ACQ:
                if (hold_now)
                    next_state = ST_CONV;
            ST_CONV:
                if (load_msb)
                    next_state = ST_OUT;
            ST_OUT:
                if (last_bit)
                    next_state = ST_DONE;
            ST_DONE:
                if (start)
                    next_state = ST_ACQ;
            default:
                next_state = ST_OFF;
        endcase
        // deselect always wins; a dsp host keeps chip select low instead
        if (cs_rise)
            next_state = ST_OFF;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            state <= ST_OFF;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------------
    // dsp mode detect: a sync falling edge while selected
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst || cs_rise)
            dsp_mode <= 1'b0;
        else if (fs_fall && !cs_s)
            dsp_mode <= 1'b1;
    end

    // ------------------------------------------------------------------
    // edge counters, restarted by each conversion start
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst || start)
        begin
            half_cnt   <= 6'h00;
            launch_cnt <= 5'h00;
        end
        else
        begin
            if (any_edge && (half_cnt != 6'h3F))
                half_cnt <= half_cnt + 6'h01;
            if (launch_edge && (launch_cnt != 5'h1F))
                launch_cnt <= launch_cnt + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // command shift register
    // ------------------------------------------------------------------
    // the word is applied only once all bits are in, so a frame cut
    // short leaves the previous configuration untouched
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cmd_reg <= CMD_RESET;
            cmd_sh  <= 8'h00;
            cmd_cnt <= 4'h0;
        end
        else
        begin
            if (start)
                cmd_cnt <= 4'h0;
            else if (cmd_take)
            begin
                cmd_sh  <= {cmd_sh[6:0], din_s};
                cmd_cnt <= cmd_cnt + 4'h1;
            end
            if (cmd_done)
                cmd_reg <= {cmd_sh[6:0], din_s};
        end
    end

    // ------------------------------------------------------------------
    // result shifter and serial output
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            shifter <= 16'h0000;
            bit_cnt <= 4'h0;
            dout    <= 1'b0;
        end
        else if (load_msb)
        begin
            // straight binary word, msb on the line first
            shifter <= {fifo_word[RES_BITS-2:0], 1'b0};
            dout    <= fifo_word[RES_BITS-1];
            bit_cnt <= 4'h0;
        end
        else if ((state == ST_OUT) && launch_edge)
        begin
            shifter <= {shifter[RES_BITS-2:0], 1'b0};
            dout    <= last_bit ? 1'b0 : shifter[RES_BITS-1];
            bit_cnt <= bit_cnt + 4'h1;
        end
        else if (state != ST_OUT)
            dout <= 1'b0;
    end

    // ------------------------------------------------------------------
    // frame-sync out: one serial period from the msb launch edge
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            frame_sync_out <= 1'b0;
        else if (load_msb)
            frame_sync_out <= dsp_mode;
        else if (launch_edge || !dsp_mode)
            frame_sync_out <= 1'b0;
    end

    // ------------------------------------------------------------------
    // track/hold and converter stepping
    // ------------------------------------------------------------------
    // hold stays closed after the word until the next start re-arms it
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            track_hold <= 1'b0;
            conv_start <= 1'b0;
            conv_step  <= 1'b0;
        end
        else
        begin
            if (start)
                track_hold <= 1'b0;
            else if (hold_now)
                track_hold <= 1'b1;
            conv_start <= hold_now;
            // serial clock paces the core unless internal clock is chosen
            conv_step  <= (state == ST_CONV) && !int_clk && sc_fall;
        end
    end

    // ------------------------------------------------------------------
    // pin side outputs: enable, end of conversion, power control
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            dout_oe      <= 1'b0;
            eoc_n        <= 1'b1;
            analog_awake <= 1'b0;
            ref_on       <= 1'b0;
            buf_on       <= 1'b0;
        end
        else
        begin
            dout_oe      <= !cs_s;
            // external clock keeps end of conversion parked high
            eoc_n        <= !(int_clk && (state == ST_CONV) && fifo_vld);
            analog_awake <= (next_state != ST_OFF);
            if (pd_sel == PD_EXT_REF)
            begin
                ref_on <= 1'b0;
                buf_on <= 1'b0;
            end
            else
            begin
                // internal reference: field picks what stays up when idle
                ref_on <= !cs_s || (pd_sel == PD_ALL_ON)
                          || (pd_sel == PD_REF_ON);
                buf_on <= !cs_s || (pd_sel == PD_ALL_ON);
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration outputs straight from the command register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            analog_input_channel <= CMD_RESET[CMD_CH_LSB +: 3];
            scan_mode            <= CMD_RESET[CMD_SCN_LSB +: 2];
        end
        else
        begin
            analog_input_channel <= cmd_reg[CMD_CH_LSB +: 3];
            scan_mode            <= cmd_reg[CMD_SCN_LSB +: 2];
        end
    end
endmodule

//--- hw/asc_pkg.sv
/*
 * package for the serial conversion control block: command layout,
 * reset values, edge counts and state codes.
 * assumes: included by the top module and the fifo through asc_pkg::*.
 */
package asc_pkg;
    // ------------------------------------------------------------------
    // command word layout
    // ------------------------------------------------------------------
    localparam int        CMD_BITS    = 8;       // command bits per frame
    localparam logic [7:0] CMD_RESET  = 8'h06;   // power-up command value
    localparam int        CMD_CH_LSB  = 5;       // channel select 7:5
    localparam int        CMD_SCN_LSB = 3;       // scan field 4:3
    localparam int        CMD_PD_LSB  = 1;       // power-down field 2:1
    localparam int        CMD_CLK_BIT = 0;       // 1 = internal clock
    localparam logic [1:0] PD_ALL_ON  = 2'h0;    // ref and buffer kept on
    localparam logic [1:0] PD_REF_ON  = 2'h2;    // ref on, buffer off
    localparam logic [1:0] PD_EXT_REF = 2'h3;    // external reference

    // ------------------------------------------------------------------
    // serial frame timing, in serial clock edges
    // ------------------------------------------------------------------
    localparam int        RES_BITS    = 16;      // result word width
    localparam logic [4:0] DATA_EDGE_8  = 5'h08; // msb launch edge, 8-bit
    localparam logic [4:0] DATA_EDGE_16 = 5'h10; // msb launch edge, 16-bit
    localparam logic [5:0] ACQ_HALF_8   = 6'h0B; // half cycles of acquisition
    localparam logic [5:0] ACQ_HALF_16  = 6'h17; // 11.5 cycles = 23 halves
    localparam logic [3:0] LAST_BIT     = 4'hF;  // index of last result bit
    localparam logic [4:0] PIN_IDLE     = 5'h12; // synced pins at rest: cs_n, sync high
    localparam int        FIFO_DEPTH  = 32;      // result buffer depth

    // ------------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_OFF  = 5'h01,    // chip deselected, shut down
        ST_ACQ  = 5'h02,    // tracking the input
        ST_CONV = 5'h04,    // holding, converting
        ST_OUT  = 5'h08,    // shifting the result
        ST_DONE = 5'h10     // result sent, waiting for re-arm
    } asc_state_type;
endpackage

//--- hw/asc_fifo.sv
/*
 * synchronous result fifo with valid/ready on both sides.
 * assumes: one clock, synchronous active-high reset; full and empty
 * are held in flip-flops so the ready/valid outputs are registered.
 */
`timescale 1ns/1ps
module asc_fifo
    import asc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
)(
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];      // storage words
    logic [AW-1:0]    wr_ptr;           // write index
    logic [AW-1:0]    rd_ptr;           // read index
    logic [AW:0]      count;            // words held
    logic [AW:0]      next_count;       // count after this cycle
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // ------------------------------------------------------------------
    // occupancy
    // ------------------------------------------------------------------
    always_comb
    begin
        next_count = count;
        if (push && !pop)
            next_count = count + 1'b1;
        else if (pop && !push)
            next_count = count - 1'b1;
    end

    assign out_data = mem[rd_ptr];

    // flags are registered so both ready and valid come from flops
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count     <= next_count;
            in_ready  <= (next_count != (AW+1)'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end

    // storage has no reset; contents are only read behind out_valid
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
endmodule

//--- verif/asc_ctrl_properties.sv
/* port assertions and covers for the conversion control block.
   assumes: bound into asc_ctrl; one mclk domain, sync reset. */
`timescale 1ns/1ps
module asc_ctrl_properties
    import asc_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic frame_sync_out,
    input wire logic eoc_n,
    input wire logic track_hold,
    input wire logic conv_start,
    input wire logic conv_step,
    input wire logic analog_awake,
    input wire logic result_ready
);
    // ----
    // relations; six samples cover the pin sync latency
    // ----
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    a_oe_released: assert property (cs_n [*6] |-> !dout_oe)
        else $error("dout driven while deselected");
    a_oe_wakes: assert property ((!cs_n) [*6] |-> dout_oe)
        else $error("dout not driven while selected");
    a_awake_off: assert property (cs_n [*6] |-> !analog_awake)
        else $error("analog awake while deselected");
    a_start_holds: assert property (conv_start |-> ##[0:1] track_hold)
        else $error("start without hold");
    a_start_single: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    a_step_holds: assert property (conv_step |-> track_hold)
        else $error("step outside conversion");
    a_fso_period: assert property ($rose(frame_sync_out) |->
        frame_sync_out [*7] ##[1:2] !frame_sync_out)
        else $error("frame sync out width wrong");
    a_fso_driven: assert property (frame_sync_out |-> dout_oe)
        else $error("frame sync out with dout released");
    a_eoc_converting: assert property ($fell(eoc_n) |-> track_hold)
        else $error("eoc outside conversion");
    a_idle_low: assert property ((!dout_oe) [*3] |-> !dout)
        else $error("dout high while idle");
    a_rearm_track: assert property ($rose(analog_awake) |-> !track_hold)
        else $error("frame began in hold");
    c_start: cover property (conv_start);
    c_fso: cover property ($rose(frame_sync_out));
    c_eoc: cover property ($fell(eoc_n));
    c_full: cover property (!result_ready);
endmodule
bind asc_ctrl asc_ctrl_properties #(.DEPTH(DEPTH)) chk_u (.mclk, .sys_rst, .cs_n,
    .dout, .dout_oe, .frame_sync_out, .eoc_n, .track_hold, .conv_start,
    .conv_step, .analog_awake, .result_ready);

//--- verif/asc_host_model.sv
/* host serial port model: framing, command bits, result capture.
   assumes: tasks called at a falling mclk edge; sclk 400 ns. */
`timescale 1ns/1ps
module asc_host_model (
    input wire logic mclk,
    output logic     cs_n,
    output logic     sclk,
    output logic     din,
    output logic     frame_sync_in,
    input wire logic dout,
    input wire logic frame_sync_out
);
    logic [15:0] word;   // captured result
    logic [7:0]  sh;     // command bits left
    int          ones;   // high samples before the msb
    int          fso;    // captures with frame sync out high
    int          got;    // bits captured
    int          halves; // sclk edges this frame
    bit          dsp;    // frame mode
    event        word_ev;
    initial
    begin
        cs_n = 1'h1;
        sclk = 1'h0;          // stands still between frames
        din = 1'h0;
        frame_sync_in = 1'h1;
    end
    // ----
    // frame tasks
    // ----
    // sample one full period after launch, just before the next launch edge, clear of sync delay
    task automatic grab(input int k, input int n);
        if (dsp ? (got > 0 || frame_sync_out) : k > n)
        begin
            word = {word[14:0], dout};
            got++;
            fso += frame_sync_out;
        end
        else
            ones += dout;
    endtask
    task automatic frame(input logic [7:0] cmd, input bit d, input int n);
        word = 16'h0000;
        ones = 0;
        fso = 0;
        got = 0;
        halves = 0;
        dsp = d;
        sh = cmd;
        cs_n = 1'h0;
        repeat (16) @(negedge mclk);
        if (d)
        begin
            frame_sync_in = 1'h0;
            repeat (8) @(negedge mclk);
            frame_sync_in = 1'h1;
            repeat (8) @(negedge mclk);
        end
        for (int k = 1; k <= 40 && got < 16; k++)
        begin
            if (!d) din = sh[7];
            repeat (4) @(negedge mclk);
            if (d) grab(k, n);
            sclk = 1'h1;
            halves++;
            if (d) din = sh[7];
            sh = sh << 1;
            repeat (4) @(negedge mclk);
            if (!d) grab(k, n);
            sclk = 1'h0;
            halves++;
        end
        -> word_ev;
    endtask
    task automatic close;
        cs_n = 1'h1;
        din = ~din;   // released line shows no stale level
        repeat (16) @(negedge mclk);
    endtask
endmodule

//--- verif/tb_top.sv
/* self-checking bench: host model on the pins, core model on results.
   assumes: design and host model compiled first. */
`timescale 1ns/1ps
module tb_top;
    import asc_pkg::*;
    logic mclk = 1'h0;
    logic sys_rst = 1'h1;
    logic transfer_width_select = 1'h0;
    logic [15:0] result_data = 16'h0000;
    logic result_valid = 1'h0;
    logic cs_n, sclk, din, frame_sync_in, dout, dout_oe, frame_sync_out;
    logic result_ready, eoc_n, track_hold, conv_start, conv_step;
    logic analog_awake, ref_on, buf_on;
    logic [2:0] analog_input_channel;
    logic [1:0] scan_mode;
    logic [15:0] q[$]; // words accepted by the design, oldest first
    int seed = 32'hBE11;
    int num_errors = 0, check_count = 0, cyc = 0, pend = 0, starts, hs, steps;
    bit took, mute = 1'h1, eoc_lo;
    asc_ctrl dut_u (.mclk, .sys_rst, .cs_n, .sclk, .din, .frame_sync_in,
        .transfer_width_select, .result_data, .result_valid, .result_ready,
        .dout, .dout_oe, .frame_sync_out, .eoc_n, .track_hold, .conv_start,
        .conv_step, .analog_awake, .ref_on, .buf_on, .analog_input_channel,
        .scan_mode);
    asc_host_model host_u (.mclk, .cs_n, .sclk, .din, .frame_sync_in,
        .dout, .frame_sync_out);
    always #25 mclk = ~mclk;
    // ----
    // core model and watchers
    // ----
    // note accepted words, starts and eoc; cut a hang short
    always @(posedge mclk)
    begin
        took = result_valid && result_ready;
        if (took) q.push_back(result_data);
        if (conv_start) starts++;
        if (conv_step) steps++;
        if (conv_start) hs = host_u.halves;
        if (!eoc_n) eoc_lo = 1'h1;
        cyc++;
        if (cyc == 40000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    // word held until taken; muted core stalls so the buffer drains
    always @(negedge mclk)
    begin
        if (took) pend--;
        if (conv_start && !mute) pend++;
        if (took || !result_valid) result_data <= 16'($random(seed));
        result_valid <= pend > 0;
    end
    always @(host_u.word_ev) chk("word", q.pop_front(), host_u.word);
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    // one frame; dsp frames last, pd walks all four codes
    task automatic run(input int i);
        logic [7:0] cmd;
        logic [1:0] pd;
        int n;
        pd = i[1:0];
        cmd = {i[2:0], 2'($random(seed)), pd, 1'(i == 33)};
        n = i[0] ? 16 : 8;
        transfer_width_select = i[0];
        mute = i < 33;
        starts = 0;
        steps = 0;
        eoc_lo = 1'h0;
        host_u.frame(cmd, i >= 40, n);
        chk("channel", 16'(cmd[7:5]), 16'(analog_input_channel));
        chk("scan", 16'(cmd[4:3]), 16'(scan_mode));
        chk("power", pd == 3 ? 0 : 3, 16'({ref_on, buf_on}));
        chk("pre", 0, 16'(host_u.ones));
        chk("starts", 1, 16'(starts));
        chk("fso", 16'(i >= 40), 16'(host_u.fso));
        chk("hold", 1, 16'(track_hold));
        if (i < 40) chk("acq", 1, 16'(hs == (i[0] ? ACQ_HALF_16 : ACQ_HALF_8)));
        if (i < 33) chk("steps", i[0] ? 5 : 3, 16'(steps));
        if (i == 33 || i == 35) chk("eoc", 16'(i == 33), 16'(eoc_lo));
        host_u.close();
        chk("oe", 0, 16'(dout_oe));
        chk("awake", 0, 16'(analog_awake));
        chk("down", pd == 0 ? 3 : pd == 2 ? 2 : 0, 16'({ref_on, buf_on}));
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(negedge mclk);
        sys_rst = 1'h0;
        repeat (4) @(negedge mclk);
        chk("ready", 1, 16'(result_ready));
        @(posedge mclk);
        pend = 33;
        repeat (60) @(negedge mclk);
        chk("ready", 0, 16'(result_ready));
        chk("depth", FIFO_DEPTH, 16'(q.size()));
        for (int i = 0; i < 44; i++) run(i);
        report_and_stop();
    end
endmodule
